// [rtl/ppeic_pkg.sv]
// constants and carrier types for the port pin edge interrupt configuration block
// assumes one 25 MHz system clock and a byte-wide register port with bank select
package ppeic_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam logic [7:0] CFG_ADDR      = 8'hEA;
	localparam logic       CFG_BANK      = 1'h1;
	localparam logic [7:0] CFG_RESET     = 8'h00;
	localparam logic [7:0] RDATA_IDLE    = 8'h00;

	// ****************************************
	// field layout, one two-bit field per pin
	// ****************************************
	localparam int         NUM_LINES     = 4;
	localparam int         FIELD_W       = 2;
	localparam int         LSB_PIN_FOUR  = 0;
	localparam int         LSB_PIN_FIVE  = 2;
	localparam int         LSB_PIN_SIX   = 4;
	localparam int         LSB_PIN_SEVEN = 6;

	// ****************************************
	// edge modes
	// ****************************************
	typedef enum logic [1:0] {
		MODE_OFF  = 2'h0,
		MODE_FALL = 2'h1,
		MODE_RISE = 2'h2,
		MODE_BOTH = 2'h3
	} ppeic_mode_type;

	// ****************************************
	// register access request
	// ****************************************
	typedef struct packed {
		logic [7:0] addr;
		logic       bank;
		logic       wr;
		logic       rd;
		logic [7:0] wdata;
	} ppeic_req_type;

endpackage : ppeic_pkg

// [rtl/ppeic_edge_irq.sv]
// edge interrupt detection for port pins four to seven, with its configuration register
// assumes pins are asynchronous to mclk_in and the cpu issues one access per cycle
//
// How it works
// - code 01 fires on each falling edge; code 00 disables the line.
// - code 10 fires on rising edges only, falling edges ignored.
// - code 11 fires on every edge, either direction.
// - bits 1..0 choose the edge mode for pin four.
// - bits 5..4 choose the edge mode for pin six.
`timescale 1ns/1ps
module ppeic_edge_irq (
	// clock and reset
	input  wire logic                               mclk_in,
	input  wire logic                               resetn_in,
	// register port
	input  wire ppeic_pkg::ppeic_req_type           req_in,
	output logic [7:0]                              rdata_out,
	// pins, bit 0 is pin four up to bit 3 pin seven
	input  wire logic [ppeic_pkg::NUM_LINES-1:0]    port_pin_in,
	// one-cycle interrupt requests, same bit order
	output logic [ppeic_pkg::NUM_LINES-1:0]         ext_irq_out
);
	import ppeic_pkg::*;

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic reg_hit(input ppeic_req_type r);
		reg_hit = (r.addr == CFG_ADDR) && (r.bank == CFG_BANK);
	endfunction : reg_hit

	function automatic ppeic_mode_type field_of(input logic [7:0] cfg, input int idx);
		logic [7:0] sh;
		sh = cfg >> idx;
		field_of = ppeic_mode_type'(sh[1:0]);
	endfunction : field_of

	function automatic logic fires(input ppeic_mode_type m, input logic rise, input logic fall);
		unique case (m)
			MODE_OFF:  fires = 1'b0;
			MODE_FALL: fires = fall;
			MODE_RISE: fires = rise;
			MODE_BOTH: fires = rise | fall;
		endcase
	endfunction : fires

	localparam int LSB_OF [NUM_LINES] = '{LSB_PIN_FOUR, LSB_PIN_FIVE, LSB_PIN_SIX, LSB_PIN_SEVEN};

	// ****************************************
	// configuration register
	// ****************************************
	logic [7:0]           port3_edge_interrupt_config;
	logic                 cfg_wr;
	logic                 cfg_rd;

	assign cfg_wr = req_in.wr && reg_hit(req_in);
	assign cfg_rd = req_in.rd && reg_hit(req_in);

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			port3_edge_interrupt_config <= CFG_RESET;
		end else if (cfg_wr) begin
			port3_edge_interrupt_config <= req_in.wdata;
		end
	end

	// unmapped reads return zero so a wrong bank never leaks the field
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			rdata_out <= RDATA_IDLE;
		end else if (cfg_rd) begin
			rdata_out <= port3_edge_interrupt_config;
		end else begin
			rdata_out <= RDATA_IDLE;
		end
	end

	// ****************************************
	// pin synchronisers and edge detect
	// ****************************************
	logic [NUM_LINES-1:0] sync1;
	logic [NUM_LINES-1:0] sync2;
	logic [NUM_LINES-1:0] sync3;
	logic [NUM_LINES-1:0] settled;
	logic                 primed;
	logic [2:0]           filled;
	logic [NUM_LINES-1:0] agree;
	logic [NUM_LINES-1:0] rise;
	logic [NUM_LINES-1:0] fall;

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			sync1 <= '0;
			sync2 <= '0;
			sync3 <= '0;
			filled <= '0;
		end else begin
			sync1 <= port_pin_in;
			sync2 <= sync1;
			sync3 <= sync2;
			// marks the stages that hold a real pin sample since reset
			filled <= {filled[1:0], 1'b1};
		end
	end

	assign agree = ~(sync2 ^ sync3);

	// the first settled level after reset is learnt, not reported as an edge
	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			primed  <= 1'b0;
			settled <= '0;
		end else if (!primed) begin
			// wait for stage three to hold a real sample, else the reset zeros
			// are learnt and a pin high at reset gives a false rise
			primed  <= filled[2] & (&agree);
			settled <= sync3;
		end else begin
			settled <= (agree & sync3) | (~agree & settled);
		end
	end

	assign rise = {NUM_LINES{primed}} & agree & sync3 & ~settled;
	assign fall = {NUM_LINES{primed}} & agree & ~sync3 & settled;

	// ****************************************
	// per line mode selection
	// ****************************************
	ppeic_mode_type       mode [NUM_LINES];

	genvar gi;
	generate
		for (gi = 0; gi < NUM_LINES; gi++) begin : g_line
			assign mode[gi] = field_of(port3_edge_interrupt_config, LSB_OF[gi]);

			always_ff @(posedge mclk_in) begin
				if (!resetn_in) begin
					ext_irq_out[gi] <= 1'b0;
				end else begin
					ext_irq_out[gi] <= fires(mode[gi], rise[gi], fall[gi]);
				end
			end

			property p_fall_fires;
				@(posedge mclk_in) disable iff (!resetn_in)
				(mode[gi] == MODE_FALL && fall[gi]) |=> ext_irq_out[gi];
			endproperty
			a_fall_fires: assert property (p_fall_fires)
				else $error("falling edge in fall mode raised no interrupt");

			property p_fall_only;
				@(posedge mclk_in) disable iff (!resetn_in)
				(mode[gi] == MODE_FALL) |=> (ext_irq_out[gi] == $past(fall[gi]));
			endproperty
			a_fall_only: assert property (p_fall_only)
				else $error("fall mode did not follow falling edges exactly");

			property p_off_silent;
				@(posedge mclk_in) disable iff (!resetn_in)
				(mode[gi] == MODE_OFF) |=> !ext_irq_out[gi];
			endproperty
			a_off_silent: assert property (p_off_silent)
				else $error("disabled line raised an interrupt");

			property p_rise_only;
				@(posedge mclk_in) disable iff (!resetn_in)
				(mode[gi] == MODE_RISE) |=> (ext_irq_out[gi] == $past(rise[gi]));
			endproperty
			a_rise_only: assert property (p_rise_only)
				else $error("rise mode did not follow rising edges exactly");

			property p_both_edges;
				@(posedge mclk_in) disable iff (!resetn_in)
				(mode[gi] == MODE_BOTH && (rise[gi] || fall[gi])) ##1 (!rise[gi] && !fall[gi])
				|=> $fell(ext_irq_out[gi]);
			endproperty
			a_both_edges: assert property (p_both_edges)
				else $error("both-edge mode did not give a single-cycle pulse");
		end
	endgenerate

	// ****************************************
	// register checks
	// ****************************************
	property p_low_field;
		@(posedge mclk_in) disable iff (!resetn_in)
		cfg_wr |=> (mode[0] == ppeic_mode_type'($past(req_in.wdata[1:0])));
	endproperty
	a_low_field: assert property (p_low_field)
		else $error("bits 1..0 do not steer pin four");

	property p_six_field;
		@(posedge mclk_in) disable iff (!resetn_in)
		cfg_wr |=> (mode[2] == ppeic_mode_type'($past(req_in.wdata[5:4])));
	endproperty
	a_six_field: assert property (p_six_field)
		else $error("bits 5..4 do not steer pin six");

	property p_five_field;
		@(posedge mclk_in) disable iff (!resetn_in)
		cfg_wr |=> (mode[1] == ppeic_mode_type'($past(req_in.wdata[3:2])));
	endproperty
	a_five_field: assert property (p_five_field)
		else $error("bits 3..2 do not steer pin five");

	property p_seven_field;
		@(posedge mclk_in) disable iff (!resetn_in)
		cfg_wr |=> (mode[3] == ppeic_mode_type'($past(req_in.wdata[7:6])));
	endproperty
	a_seven_field: assert property (p_seven_field)
		else $error("bits 7..6 do not steer pin seven");

	property p_readback;
		@(posedge mclk_in) disable iff (!resetn_in)
		cfg_wr ##1 (cfg_rd && !cfg_wr) |=> (rdata_out == $past(req_in.wdata, 2));
	endproperty
	a_readback: assert property (p_readback)
		else $error("written value not read back");

	property p_reset_zero;
		@(posedge mclk_in)
		!resetn_in |=> (port3_edge_interrupt_config == CFG_RESET && ext_irq_out == '0);
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("register or outputs not cleared by reset");

endmodule : ppeic_edge_irq

// [verif/ppeic_pin_source.sv]
// external signal sources for port pins four to seven
// assumes levels come from the bench; pins move off the clock
`timescale 1ns/1ps
module ppeic_pin_source (
	// commanded levels
	input  wire logic [3:0] level_in,
	// pin levels
	output wire logic [3:0] port_pin_out
);
	// ****************************************
	// pin drive
	// ****************************************
	// offset from the clock edge, like an unrelated source
	assign #7 port_pin_out = level_in;
endmodule : ppeic_pin_source

// [verif/test_port_pin_edge_irq_config.sv]
// self-checking bench for the edge interrupt configuration block
// assumes the register port and pin timing given in the block notes
`timescale 1ns/1ps
module test_port_pin_edge_irq_config;
	import ppeic_pkg::*;
	// ****************************************
	// signals
	// ****************************************
	logic          mclk_in;
	logic          resetn_in;
	ppeic_req_type req_in;
	logic [7:0]    rdata_out;
	logic [3:0]    level;
	logic [3:0]    port_pin_in;
	logic [3:0]    ext_irq_out;
	int            cnt[4];
	int            snap[4];
	int            n_mismatch;
	int            checks_done;

	ppeic_edge_irq u_ppeic_edge_irq (.mclk_in(mclk_in), .resetn_in(resetn_in), .req_in(req_in),
		.rdata_out(rdata_out), .port_pin_in(port_pin_in), .ext_irq_out(ext_irq_out));
	ppeic_pin_source u_ppeic_pin_source (.level_in(level), .port_pin_out(port_pin_in));

	initial begin
		mclk_in = 1'b0;
		forever #20 mclk_in = ~mclk_in;
	end

	// pulses are one cycle wide, so one count per high cycle
	always @(posedge mclk_in) begin
		for (int j = 0; j < 4; j++) if (ext_irq_out[j] === 1'b1) cnt[j]++;
	end

	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic acc(input logic [7:0] a, input logic b, input logic w, input logic [7:0] d);
		@(posedge mclk_in) req_in <= '{addr: a, bank: b, wr: w, rd: ~w, wdata: d};
		@(posedge mclk_in) req_in <= '0;
	endtask : acc

	task automatic rd_check(input logic [7:0] a, input logic b, input logic [7:0] exp);
		acc(a, b, 1'b0, 8'h00);
		#1 check("rdata", exp, rdata_out);
	endtask : rd_check

	task automatic edge_count(input int i, input int exp);
		repeat (10) @(posedge mclk_in);
		for (int j = 0; j < 4; j++) check($sformatf("pulses line %0d", j), 8'((j == i) ? exp : 0), 8'(cnt[j] - snap[j]));
		snap = cnt;
	endtask : edge_count

	task automatic line_test(input int i, input logic [1:0] m);
		acc(CFG_ADDR, CFG_BANK, 1'b1, 8'({6'h00, m} << (2 * i)));
		snap = cnt;
		@(posedge mclk_in) level[i] <= 1'b1;
		edge_count(i, int'(m[1]));
		@(posedge mclk_in) level[i] <= 1'b0;
		edge_count(i, int'(m[0]));
	endtask : line_test

	task automatic pulse_reset;
		@(posedge mclk_in) resetn_in <= 1'b0;
		repeat (3) @(posedge mclk_in);
		resetn_in <= 1'b1;
	endtask : pulse_reset

	task automatic print_verdict;
		if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : print_verdict

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		resetn_in = 1'b0;
		req_in = '0;
		level = 4'h0;
		repeat (8) @(posedge mclk_in);
		resetn_in <= 1'b1;
		repeat (5) @(posedge mclk_in);
		rd_check(CFG_ADDR, CFG_BANK, 8'h00);
		acc(CFG_ADDR, CFG_BANK, 1'b1, 8'hA5);
		rd_check(CFG_ADDR, CFG_BANK, 8'hA5);
		acc(CFG_ADDR, 1'b0, 1'b1, 8'hFF);
		rd_check(CFG_ADDR, CFG_BANK, 8'hA5);
		rd_check(8'hEB, CFG_BANK, 8'h00);
		acc(CFG_ADDR, CFG_BANK, 1'b1, 8'h5A);
		rd_check(CFG_ADDR, CFG_BANK, 8'h5A);
		// write then read on the very next cycle, no idle gap
		@(posedge mclk_in) req_in <= '{addr: CFG_ADDR, bank: CFG_BANK, wr: 1'b1, rd: 1'b0, wdata: 8'h3C};
		rd_check(CFG_ADDR, CFG_BANK, 8'h3C);
		for (int i = 0; i < 4; i++) for (int m = 0; m < 4; m++) line_test(i, 2'(m));
		// mid-run reset with a written register and pin four held high
		acc(CFG_ADDR, CFG_BANK, 1'b1, 8'hC3);
		@(posedge mclk_in) level[0] <= 1'b1;
		pulse_reset();
		rd_check(CFG_ADDR, CFG_BANK, 8'h00);
		// arm both edges at once after release: the held level must be learnt
		pulse_reset();
		acc(CFG_ADDR, CFG_BANK, 1'b1, 8'h03);
		snap = cnt;
		edge_count(0, 0);
		@(posedge mclk_in) level[0] <= 1'b0;
		edge_count(0, 1);
		print_verdict();
	end
endmodule : test_port_pin_edge_irq_config
